// *** hdl/ucm_chan.sv ***
`timescale 1ns/1ps
module ucm_chan (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic chan_a_serial_in,
	output logic chan_a_serial_out,
	input wire logic chan_a_clear_send_in_n,
	output logic chan_a_req_send_out_n
);

	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic rxd_sync;
	logic cts_high;
	logic bus_ack;
	logic bus_req;
	logic bus_take;
	logic rd_take;
	logic wr_take;
	logic [31:0] next_readdata;
	ucm_pkg::ucm_mode_one_s mode_one;
	ucm_pkg::ucm_mode_two_s mode_two;
	logic ptr_two;
	logic tx_en;
	logic rx_en;
	logic tx_1x;
	logic opr_rts;
	logic [15:0] divisor;
	logic [15:0] div_cnt;
	logic tick;
	logic echo_mode;
	logic local_mode;
	logic echo_active;
	logic [3:0] echo_hold;
	logic five_bits;
	logic has_par;
	logic [1:0] shamt;
	logic [7:0] char_mask;
	logic [2:0] last_idx;
	logic [5:0] stop_ticks;
	ucm_pkg::ucm_ser_e tx_state;
	logic [5:0] tx_cnt;
	logic [2:0] tx_idx;
	logic [7:0] tx_shift;
	logic tx_par;
	logic tx_line;
	logic [7:0] tx_hold;
	logic tx_hold_vld;
	logic tx_load;
	logic tx_accept;
	logic tx_empty;
	logic next_tx_par;
	ucm_pkg::ucm_ser_e rx_state;
	logic [3:0] rx_cnt;
	logic [2:0] rx_idx;
	logic [7:0] rx_shift;
	logic rx_par_bit;
	logic rx_src;
	logic rx_stop_evt;
	logic [7:0] rx_aligned;
	logic [7:0] rx_data;
	logic rx_rdy;
	logic rx_frame_err;
	logic rx_parity_err;
	logic rts_auto;
	logic [4:0] rts_cnt;
	logic rts_clear;
	ucm_pkg::ucm_status_s status;

	// Pins come from the line, so two flops before any use
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 2'b11;
			pin_sync <= 2'b11;
		end else begin
			pin_meta <= {chan_a_clear_send_in_n, chan_a_serial_in};
			pin_sync <= pin_meta;
		end
	end
	assign rxd_sync = pin_sync[0];
	assign cts_high = pin_sync[1];

	// Bus: one wait cycle, then the request is taken
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign bus_take = bus_req & bus_ack;
	assign rd_take = bus_take & avs_read;
	assign wr_take = bus_take & avs_write;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	always_comb begin
		case (avs_address)
		ucm_pkg::ADDR_MODE: begin
			next_readdata = ptr_two ? {24'h000000, mode_two} :
				{24'h000000, mode_one};
		end
		ucm_pkg::ADDR_CTRL: next_readdata = {29'h00000000, tx_1x, rx_en, tx_en};
		ucm_pkg::ADDR_STATUS: next_readdata = {27'h0000000, status};
		ucm_pkg::ADDR_DATA: next_readdata = {24'h000000, rx_data};
		ucm_pkg::ADDR_OPORT: next_readdata = {31'h00000000, opr_rts};
		ucm_pkg::ADDR_DIV: next_readdata = {16'h0000, divisor};
		default: next_readdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !bus_ack) begin
			avs_readdata <= next_readdata;
		end
	end

	// Shared mode address; pointer moves only off mode one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_one <= ucm_pkg::MODE_ONE_RST;
			mode_two <= ucm_pkg::MODE_TWO_RST;
			ptr_two <= 1'b0;
		end else if (bus_take && avs_address == ucm_pkg::ADDR_MODE) begin
			if (!ptr_two) begin
				if (avs_write) begin
					mode_one <= ucm_pkg::ucm_mode_one_s'(avs_writedata[7:0]);
				end
				ptr_two <= 1'b1;
			end else if (avs_write) begin
				mode_two <= ucm_pkg::ucm_mode_two_s'(avs_writedata[7:0]);
			end
		end else if (wr_take && avs_address == ucm_pkg::ADDR_CTRL &&
			avs_writedata[ucm_pkg::CTRL_PTR_RST_BIT]) begin
			ptr_two <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_en <= 1'b0;
			rx_en <= 1'b0;
			tx_1x <= 1'b0;
			divisor <= ucm_pkg::DIV_RST;
		end else if (wr_take && avs_address == ucm_pkg::ADDR_CTRL) begin
			tx_en <= avs_writedata[ucm_pkg::CTRL_TX_EN_BIT];
			rx_en <= avs_writedata[ucm_pkg::CTRL_RX_EN_BIT];
			tx_1x <= avs_writedata[ucm_pkg::CTRL_TX_1X_BIT];
		end else if (wr_take && avs_address == ucm_pkg::ADDR_DIV) begin
			divisor <= avs_writedata[15:0];
		end
	end

	// Sixteenth-bit tick shared by both directions
	assign tick = (div_cnt == 16'h0000);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= tick ? divisor : div_cnt - 16'h0001;
		end
	end

	// Mode decode is combinational: a write acts at once
	assign echo_mode = (mode_two.chan_mode == ucm_pkg::CM_ECHO) ||
		(mode_two.chan_mode == ucm_pkg::CM_REMOTE);
	assign local_mode = (mode_two.chan_mode == ucm_pkg::CM_LOCAL);
	assign echo_active = echo_mode || (echo_hold != 4'h0);

	// Character shape from mode one
	assign five_bits = (mode_one.char_bits == 2'b00);
	assign has_par = (mode_one.parity_mode != ucm_pkg::PARITY_NONE);
	assign shamt = 2'b11 - mode_one.char_bits;
	assign char_mask = 8'hff >> shamt;
	assign last_idx = {1'b0, mode_one.char_bits} + 3'h4;

	always_comb begin
		if (tx_1x) begin
			stop_ticks = mode_two.stop_len[3] ? ucm_pkg::STOP_TWO_BIT :
				ucm_pkg::STOP_ONE_BIT;
		end else if (mode_two.stop_len[3]) begin
			stop_ticks = {2'b00, mode_two.stop_len} +
				ucm_pkg::STOP_LONG_BASE;
		end else if (five_bits) begin
			stop_ticks = {2'b00, mode_two.stop_len} + ucm_pkg::STOP_SHORT_BASE +
				ucm_pkg::STOP_FIVE_EXTRA;
		end else begin
			stop_ticks = {2'b00, mode_two.stop_len} +
				ucm_pkg::STOP_SHORT_BASE;
		end
	end

	always_comb begin
		if (mode_one.parity_mode == ucm_pkg::PARITY_WITH) begin
			next_tx_par = (^(tx_hold & char_mask)) ^ mode_one.parity_odd;
		end else begin
			next_tx_par = mode_one.parity_odd;
		end
	end

	// Start only on a tick in idle; clear-to-send looked at only here
	assign tx_load = tick && (tx_state == ucm_pkg::ST_IDLE) && tx_hold_vld &&
		!(mode_two.cts_en && cts_high);
	// Host writes to the transmitter are dropped while echoing
	assign tx_accept = wr_take && (avs_address == ucm_pkg::ADDR_DATA) &&
		tx_en && !echo_mode && !tx_hold_vld;
	assign tx_empty = (tx_state == ucm_pkg::ST_IDLE) && !tx_hold_vld;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_hold <= 8'h00;
			tx_hold_vld <= 1'b0;
		end else if (tx_accept) begin
			tx_hold <= avs_writedata[7:0];
			tx_hold_vld <= 1'b1;
		end else if (tx_load) begin
			tx_hold_vld <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state <= ucm_pkg::ST_IDLE;
			tx_line <= 1'b1;
			tx_cnt <= 6'h00;
			tx_idx <= 3'h0;
			tx_shift <= 8'h00;
			tx_par <= 1'b0;
		end else if (tick) begin
			case (tx_state)
			ucm_pkg::ST_IDLE: begin
				tx_line <= !tx_load;
				if (tx_load) begin
					tx_state <= ucm_pkg::ST_START;
					tx_shift <= tx_hold;
					tx_par <= next_tx_par;
					tx_cnt <= ucm_pkg::TICK_BIT_LAST;
				end
			end
			ucm_pkg::ST_START: begin
				tx_cnt <= tx_cnt - 6'h01;
				if (tx_cnt == 6'h00) begin
					tx_state <= ucm_pkg::ST_DATA;
					tx_line <= tx_shift[0];
					tx_shift <= tx_shift >> 1;
					tx_idx <= 3'h0;
					tx_cnt <= ucm_pkg::TICK_BIT_LAST;
				end
			end
			ucm_pkg::ST_DATA: begin
				tx_cnt <= tx_cnt - 6'h01;
				if (tx_cnt == 6'h00) begin
					tx_cnt <= ucm_pkg::TICK_BIT_LAST;
					if (tx_idx != last_idx) begin
						tx_idx <= tx_idx + 3'h1;
						tx_line <= tx_shift[0];
						tx_shift <= tx_shift >> 1;
					end else if (has_par) begin
						tx_state <= ucm_pkg::ST_PAR;
						tx_line <= tx_par;
					end else begin
						tx_state <= ucm_pkg::ST_STOP;
						tx_line <= 1'b1;
						tx_cnt <= stop_ticks - 6'h01;
					end
				end
			end
			ucm_pkg::ST_PAR: begin
				tx_cnt <= tx_cnt - 6'h01;
				if (tx_cnt == 6'h00) begin
					tx_state <= ucm_pkg::ST_STOP;
					tx_line <= 1'b1;
					tx_cnt <= stop_ticks - 6'h01;
				end
			end
			ucm_pkg::ST_STOP: begin
				tx_cnt <= tx_cnt - 6'h01;
				if (tx_cnt == 6'h00) begin
					tx_state <= ucm_pkg::ST_IDLE;
				end
			end
			default: begin
				tx_state <= ucm_pkg::ST_IDLE;
				tx_line <= 1'b1;
			end
			endcase
		end
	end

	// Receiver input: own transmitter in local loopback
	assign rx_src = local_mode ? tx_line : rxd_sync;
	assign rx_stop_evt = tick && (rx_state == ucm_pkg::ST_STOP) &&
		(rx_cnt == 4'h0);
	assign rx_aligned = rx_shift >> shamt;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= ucm_pkg::ST_IDLE;
			rx_cnt <= 4'h0;
			rx_idx <= 3'h0;
			rx_shift <= 8'h00;
			rx_par_bit <= 1'b0;
		end else if (tick) begin
			rx_cnt <= rx_cnt - 4'h1;
			case (rx_state)
			ucm_pkg::ST_IDLE: begin
				if (rx_en && !rx_src) begin
					rx_state <= ucm_pkg::ST_START;
					rx_cnt <= ucm_pkg::TICK_HALF_LAST;
				end
			end
			ucm_pkg::ST_START: begin
				if (rx_cnt == 4'h0) begin
					rx_state <= rx_src ? ucm_pkg::ST_IDLE : ucm_pkg::ST_DATA;
					rx_idx <= 3'h0;
				end
			end
			ucm_pkg::ST_DATA: begin
				if (rx_cnt == 4'h0) begin
					rx_shift <= {rx_src, rx_shift[7:1]};
					rx_idx <= rx_idx + 3'h1;
					if (rx_idx == last_idx) begin
						rx_state <= has_par ? ucm_pkg::ST_PAR : ucm_pkg::ST_STOP;
					end
				end
			end
			ucm_pkg::ST_PAR: begin
				if (rx_cnt == 4'h0) begin
					rx_par_bit <= rx_src;
					rx_state <= ucm_pkg::ST_STOP;
				end
			end
			ucm_pkg::ST_STOP: begin
				// One sample at the stop centre, whatever the stop length
				if (rx_cnt == 4'h0) begin
					rx_state <= ucm_pkg::ST_IDLE;
				end
			end
			default: rx_state <= ucm_pkg::ST_IDLE;
			endcase
		end
	end

	// New character wins over a same-cycle read pop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_data <= 8'h00;
			rx_rdy <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_parity_err <= 1'b0;
		end else if (rx_stop_evt &&
			mode_two.chan_mode != ucm_pkg::CM_REMOTE) begin
			rx_data <= rx_aligned;
			rx_rdy <= 1'b1;
			rx_frame_err <= !rx_src;
			rx_parity_err <=
				(mode_one.parity_mode == ucm_pkg::PARITY_WITH) &&
				(rx_par_bit != ((^rx_aligned) ^ mode_one.parity_odd));
		end else if (rd_take && avs_address == ucm_pkg::ADDR_DATA) begin
			rx_rdy <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_parity_err <= 1'b0;
		end
	end

	// Finish the stop bit being echoed if echo is left at its centre
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			echo_hold <= 4'h0;
		end else if (rx_stop_evt && echo_mode && tx_en) begin
			echo_hold <= ucm_pkg::TICK_HALF;
		end else if (tick && echo_hold != 4'h0) begin
			echo_hold <= echo_hold - 4'h1;
		end
	end

	// Echo retransmits the reclocked line, parity and stops as received
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_a_serial_out <= 1'b1;
		end else if (local_mode) begin
			chan_a_serial_out <= 1'b1;
		end else if (echo_active) begin
			chan_a_serial_out <= rxd_sync;
		end else begin
			chan_a_serial_out <= tx_line;
		end
	end

	// Auto-negate only once the transmitter is off and fully drained
	assign rts_auto = mode_two.rts_ctl && !tx_en && tx_empty && opr_rts;
	assign rts_clear = rts_auto && tick &&
		(rts_cnt == ucm_pkg::TICK_BIT_LAST[4:0]);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rts_cnt <= 5'h00;
		end else if (!rts_auto) begin
			rts_cnt <= 5'h00;
		end else if (tick) begin
			rts_cnt <= rts_cnt + 5'h01;
		end
	end

	// A host write in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			opr_rts <= 1'b0;
		end else if (wr_take && avs_address == ucm_pkg::ADDR_OPORT) begin
			opr_rts <= avs_writedata[0];
		end else if (rts_clear) begin
			opr_rts <= 1'b0;
		end
	end
	assign chan_a_req_send_out_n = ~opr_rts;

	// Transmitter status reads inactive while echoing
	assign status.rx_parity_err = rx_parity_err;
	assign status.rx_frame_err = rx_frame_err;
	assign status.rx_ready = rx_rdy;
	assign status.tx_empty = tx_empty && !echo_mode;
	assign status.tx_ready = !tx_hold_vld && tx_en && !echo_mode;

endmodule : ucm_chan

// *** hdl/ucm_pkg.sv ***
package ucm_pkg;
	// Byte addresses of the register window
	localparam logic [4:0] ADDR_MODE = 5'h00;
	localparam logic [4:0] ADDR_CTRL = 5'h04;
	localparam logic [4:0] ADDR_STATUS = 5'h08;
	localparam logic [4:0] ADDR_DATA = 5'h0c;
	localparam logic [4:0] ADDR_OPORT = 5'h10;
	localparam logic [4:0] ADDR_DIV = 5'h14;

	// Control register field positions
	localparam int CTRL_TX_EN_BIT = 0;
	localparam int CTRL_RX_EN_BIT = 1;
	localparam int CTRL_TX_1X_BIT = 2;
	localparam int CTRL_PTR_RST_BIT = 8;

	typedef enum logic [1:0] {
		CM_NORMAL = 2'b00,
		CM_ECHO = 2'b01,
		CM_LOCAL = 2'b10,
		CM_REMOTE = 2'b11
	} ucm_chan_mode_e;

	typedef struct packed {
		ucm_chan_mode_e chan_mode;
		logic rts_ctl;
		logic cts_en;
		logic [3:0] stop_len;
	} ucm_mode_two_s;

	typedef struct packed {
		logic [2:0] rx_ctl;
		logic [1:0] parity_mode;
		logic parity_odd;
		logic [1:0] char_bits;
	} ucm_mode_one_s;

	typedef struct packed {
		logic rx_parity_err;
		logic rx_frame_err;
		logic rx_ready;
		logic tx_empty;
		logic tx_ready;
	} ucm_status_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} ucm_ser_e;

	localparam ucm_mode_two_s MODE_TWO_RST = 8'h00;
	localparam ucm_mode_one_s MODE_ONE_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h000c;
	localparam logic [1:0] PARITY_WITH = 2'h0;
	localparam logic [1:0] PARITY_NONE = 2'h2;

	// Counts in sixteenth-bit ticks
	localparam logic [5:0] TICK_BIT_LAST = 6'h0f;
	localparam logic [3:0] TICK_HALF_LAST = 4'h7;
	localparam logic [3:0] TICK_HALF = 4'h8;
	localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
	localparam logic [5:0] STOP_LONG_BASE = 6'h11;
	localparam logic [5:0] STOP_FIVE_EXTRA = 6'h08;
	localparam logic [5:0] STOP_ONE_BIT = 6'h10;
	localparam logic [5:0] STOP_TWO_BIT = 6'h20;
endpackage : ucm_pkg

// *** bench/ucm_chan_props.sv ***
`timescale 1ns/1ps
module ucm_chan_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic chan_a_serial_in,
	input wire logic chan_a_serial_out,
	input wire logic chan_a_clear_send_in_n,
	input wire logic chan_a_req_send_out_n
);
	logic taken;
	logic op_wr;
	logic md_wr;
	logic ptr_clr;
	logic ptr_two;
	logic [7:0] mode_q;
	assign taken = (avs_read || avs_write) && !avs_waitrequest;
	assign op_wr = taken && avs_write && avs_address == ucm_pkg::ADDR_OPORT;
	assign md_wr = taken && avs_write && avs_address == ucm_pkg::ADDR_MODE
		&& ptr_two;
	assign ptr_clr = taken && avs_write && avs_writedata[8]
		&& avs_address == ucm_pkg::ADDR_CTRL;
	// Shadow pointer and mode two, rebuilt from bus traffic alone
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_two <= 1'b0;
		end else if (taken && avs_address == ucm_pkg::ADDR_MODE) begin
			ptr_two <= 1'b1;
		end else if (ptr_clr) begin
			ptr_two <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 8'h00;
		end else if (md_wr) begin
			mode_q <= avs_writedata[7:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	reset_idle_a:
		assert property ($rose(rst_n) |-> chan_a_serial_out
			&& chan_a_req_send_out_n) else $error("Line not idle after reset");
	mode_read_a:
		assert property (taken && avs_read && ptr_two
			&& avs_address == ucm_pkg::ADDR_MODE |-> avs_readdata == {24'h0, mode_q})
			else $error("Mode two readback wrong");
	mode_now_a:
		assert property (md_wr && avs_writedata[7:6] == 2'b10 |=> ##1
			chan_a_serial_out) else $error("Loopback not taken at once");
	local_mark_a:
		assert property (mode_q[7:6] == 2'b10 && $past(mode_q[7:6]) == 2'b10
			|-> chan_a_serial_out) else $error("Line not marking in loopback");
	echo_path_a:
		assert property (mode_q[6] && $past(mode_q[6], 4) |->
			chan_a_serial_out == $past(chan_a_serial_in, 3))
			else $error("Echo path broken");
	rts_set_a:
		assert property (op_wr |=> chan_a_req_send_out_n ==
			!$past(avs_writedata[0])) else $error("Request pin not following");
	rts_fall_a:
		assert property ($fell(chan_a_req_send_out_n) |-> $past(op_wr))
			else $error("Request asserted without host write");
	rts_auto_a:
		assert property ($rose(chan_a_req_send_out_n) && !$past(op_wr)
			|-> mode_q[5]) else $error("Request dropped without auto control");
	cover property (md_wr && avs_writedata[7:6] == 2'b10);
	cover property (mode_q[6] && !chan_a_serial_out);
	cover property ($rose(chan_a_req_send_out_n) && !$past(op_wr));
	cover property (mode_q[4] && !chan_a_clear_send_in_n
		&& $fell(chan_a_serial_out));
endmodule : ucm_chan_props

bind ucm_chan ucm_chan_props u_props (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.chan_a_serial_in(chan_a_serial_in),
	.chan_a_serial_out(chan_a_serial_out),
	.chan_a_clear_send_in_n(chan_a_clear_send_in_n),
	.chan_a_req_send_out_n(chan_a_req_send_out_n)
);

// *** bench/ucm_line_model.sv ***
`timescale 1ns/1ps
module ucm_line_model (
	input wire logic sys_clk,
	input wire logic tx_line,
	output logic rx_line,
	output logic cts_n
);
	// Far driver rests at mark between frames
	initial begin
		rx_line = 1'b1;
		cts_n = 1'b0;
	end
	task automatic set_cts(input logic v);
		@(posedge sys_clk);
		cts_n <= v;
	endtask : set_cts
	// Bit is 16 clocks: the bench runs the divisor at zero
	task automatic send(input logic [7:0] d, input int bits);
		for (int i = 0; i < bits + 2; i++) begin
			@(posedge sys_clk);
			rx_line <= (i == 0) ? 1'b0 : (i > bits) ? 1'b1 : d[i - 1];
			repeat (15) @(posedge sys_clk);
		end
	endtask : send
	// Clocks between two start edges; data must be all zero
	task automatic frame_gap(output int p);
		int n;
		n = 0;
		while (tx_line !== 1'b0 && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		p = 0;
		while (tx_line !== 1'b1 && p < 3000) begin
			@(posedge sys_clk);
			p++;
		end
		while (tx_line !== 1'b0 && p < 3000) begin
			@(posedge sys_clk);
			p++;
		end
	endtask : frame_gap
endmodule : ucm_line_model

// *** bench/ucm_chan_tb_top.sv ***
`timescale 1ns/1ps
module ucm_chan_tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ser_in;
	logic ser_out;
	logic cts_n;
	logic rts_n;
	logic [31:0] q;
	int err_count = 0;
	int total_checks = 0;
	logic [5:0] cases [8] = '{6'h30, 6'h37, 6'h38, 6'h3f, 6'h00, 6'h07, 6'h08,
		6'h24};
	always #20 sys_clk = ~sys_clk;
	ucm_chan DUT (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.chan_a_serial_in(ser_in),
		.chan_a_serial_out(ser_out),
		.chan_a_clear_send_in_n(cts_n),
		.chan_a_req_send_out_n(rts_n)
	);
	ucm_line_model LINE (
		.sys_clk(sys_clk),
		.tx_line(ser_out),
		.rx_line(ser_in),
		.cts_n(cts_n)
	);
	task automatic end_sim;
		$display("Checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && k < 20) begin
			@(posedge sys_clk);
			k++;
		end
		q = avs_readdata;
		if (k == 20) err_count++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic wait_fall(output int c);
		c = 0;
		while (ser_out !== 1'b0 && c < 200) begin
			@(posedge sys_clk);
			c++;
		end
	endtask : wait_fall
	// Pointer reset rides on the control write, so mode one comes next
	task automatic cfg(input logic [7:0] m1, input logic [7:0] m2,
		input logic [2:0] ctl);
		bus(1'b1, ucm_pkg::ADDR_DIV, 32'h0);
		bus(1'b1, ucm_pkg::ADDR_CTRL, {23'h0, 1'b1, 5'h0, ctl});
		bus(1'b1, ucm_pkg::ADDR_MODE, {24'h0, m1});
		bus(1'b1, ucm_pkg::ADDR_MODE, {24'h0, m2});
	endtask : cfg
	task automatic t_reset;
		bus(1'b0, ucm_pkg::ADDR_MODE, 32'h0);
		bus(1'b0, ucm_pkg::ADDR_MODE, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, ucm_pkg::ADDR_MODE, 32'h0b);
		bus(1'b0, ucm_pkg::ADDR_MODE, 32'h0);
		chk(q, 32'h0b);
		bus(1'b0, 5'h1c, 32'h0);
		chk(q, 32'h0);
	endtask : t_reset
	// Idle tick between frames is allowed, hence the one-clock slack
	// External 1x clock mode: only stop code bit 3 counts, one or two bits
	task automatic t_stop(input logic [1:0] cb, input logic [3:0] code,
		input logic x1);
		int p;
		int e;
		e = 16 * (cb + 6) + ((code < 8) ? 9 + code + ((cb == 0) ? 8 : 0)
			: 17 + code);
		if (x1) begin
			e = 16 * (cb + 6) + (code[3] ? 32 : 16);
		end
		cfg({6'h04, cb}, {4'h0, code}, {x1, 2'h1});
		fork
			LINE.frame_gap(p);
			begin
				bus(1'b1, ucm_pkg::ADDR_DATA, 32'h0);
				bus(1'b1, ucm_pkg::ADDR_DATA, 32'h0);
			end
		join
		chk(p == e || p == e + 1, 1);
		repeat (400) @(posedge sys_clk);
	endtask : t_stop
	task automatic t_auto;
		int c;
		cfg(8'h13, 8'h27, 3'h1);
		bus(1'b1, ucm_pkg::ADDR_OPORT, 32'h1);
		chk(rts_n, 0);
		bus(1'b1, ucm_pkg::ADDR_DATA, 32'h0);
		fork
			begin
				wait_fall(c);
				c = 0;
				while (rts_n !== 1'b1 && c < 300) begin
					@(posedge sys_clk);
					c++;
				end
			end
			bus(1'b1, ucm_pkg::ADDR_CTRL, 32'h0);
		join
		chk(c >= 172 && c <= 180, 1);
		bus(1'b0, ucm_pkg::ADDR_OPORT, 32'h0);
		chk(q, 32'h0);
	endtask : t_auto
	task automatic t_cts;
		int c;
		cfg(8'h13, 8'h17, 3'h1);
		LINE.set_cts(1'b1);
		bus(1'b1, ucm_pkg::ADDR_DATA, 32'h55);
		wait_fall(c);
		chk(c, 200);
		LINE.set_cts(1'b0);
		wait_fall(c);
		chk(c < 40, 1);
		repeat (40) @(posedge sys_clk);
		LINE.set_cts(1'b1);
		repeat (200) @(posedge sys_clk);
		bus(1'b0, ucm_pkg::ADDR_STATUS, 32'h0);
		chk(q[1], 1);
		cfg(8'h13, 8'h07, 3'h1);
		bus(1'b1, ucm_pkg::ADDR_DATA, 32'h55);
		wait_fall(c);
		chk(c < 40, 1);
		LINE.set_cts(1'b0);
		repeat (200) @(posedge sys_clk);
	endtask : t_cts
	// Shortest stop, back to back: receiver must look only at stop centre
	task automatic t_loop;
		int c;
		cfg(8'h13, 8'h80, 3'h3);
		bus(1'b1, ucm_pkg::ADDR_DATA, 32'ha5);
		bus(1'b1, ucm_pkg::ADDR_DATA, 32'h5a);
		wait_fall(c);
		chk(c, 200);
		repeat (150) @(posedge sys_clk);
		bus(1'b0, ucm_pkg::ADDR_STATUS, 32'h0);
		chk(q[4:2], 3'h1);
		bus(1'b0, ucm_pkg::ADDR_DATA, 32'h0);
		chk(q, 32'h5a);
	endtask : t_loop
	task automatic t_echo;
		cfg(8'h13, 8'h47, 3'h3);
		bus(1'b1, ucm_pkg::ADDR_DATA, 32'h0);
		LINE.send(8'h3c, 8);
		repeat (20) @(posedge sys_clk);
		bus(1'b0, ucm_pkg::ADDR_DATA, 32'h0);
		chk(q, 32'h3c);
		bus(1'b0, ucm_pkg::ADDR_STATUS, 32'h0);
		chk(q[1:0], 2'h0);
		cfg(8'h13, 8'hc7, 3'h2);
		LINE.send(8'h3c, 8);
		repeat (20) @(posedge sys_clk);
		bus(1'b0, ucm_pkg::ADDR_STATUS, 32'h0);
		chk(q[2], 0);
	endtask : t_echo
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		for (int i = 0; i < 8; i++) begin
			t_stop(cases[i][5:4], cases[i][3:0], 1'b0);
		end
		t_stop(2'h3, 4'h0, 1'b1);
		t_stop(2'h3, 4'h8, 1'b1);
		t_auto();
		t_cts();
		t_loop();
		t_echo();
		end_sim();
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		err_count++;
		end_sim();
	end
endmodule : ucm_chan_tb_top
